// [hdl/pvic_pkg.sv]
// Notes on behaviour
// - Drive a 3-bit request level to the core; zero means no request.
// - Level 7 is most urgent, level 1 least urgent.
// - An asserted request stays asserted until software disables it.
// - Core does a byte acknowledge read; controller returns an 8-bit vector.
// - Vectors index 256 entries; sources use 64-191, lower 64 are reserved.
// - The controller completes every acknowledge itself, never forwards it.
// - Every source, each external pin too, has its own fixed vector.
// - A per-source control register sets request level and sub-priority.
// - Nine sub-priorities per level, 63 rankings; software keeps them unique.
// - Eight sub-priorities are programmable; ninth belongs to the same pin.
// - Pin sub-priority ranks above programmable 0-3 and below 4-7.
// - Equal rank between units goes to the primary unit.
// - Two 32-bit mask registers per unit, one bit per source; cleared bit enables.
// - Each unit's global mask bit blocks every source of that unit regardless of other bits.
// - Up to seven active-low external request pins 7..1 via the edge port.
// - Each pin triggers on low level, rising, falling or both edges.
package pvic_pkg;
   localparam int NSRC = 64;
   localparam int NPIN = 7;
   localparam int LVL_W = 3;
   localparam int CTL_W = 6;
   localparam int RANK_W = 7;
   localparam int MASKALL_BIT = 0;
   localparam logic [3:0] SUB_FIXED = 4'h4;
   localparam logic [2:0] SUB_SPLIT = 3'h4;
   localparam logic [63:0] MASK_RST = 64'hffff_ffff_ffff_ffff;
   localparam logic [CTL_W-1:0] CTL_RST = 6'h00;
   localparam logic [13:0] PIN_CFG_RST = 14'h0000;
   // In-unit offsets; second unit sits one stride above the first
   localparam logic [8:0] UOFF_MASK_HI = 9'h000;
   localparam logic [8:0] UOFF_MASK_LO = 9'h004;
   localparam logic [8:0] UOFF_STAT = 9'h008;
   localparam logic [8:0] UOFF_CTL = 9'h100;
   localparam logic [11:0] OFF_UNIT_B = 12'h200;
   localparam logic [11:0] OFF_PIN_CFG = 12'h400;
   localparam logic [11:0] OFF_PIN_FLAG = 12'h404;
   localparam logic [11:0] OFF_PIN_LVL = 12'h408;
   localparam logic [11:0] OFF_CORE_LVL = 12'h40c;
   localparam logic [7:0] VEC_USER_MIN = 8'h40;
   localparam logic [7:0] VEC_BASE_A = 8'h40;
   localparam logic [7:0] VEC_BASE_B = 8'h80;
   localparam logic [7:0] VEC_SPURIOUS = 8'h18;

   typedef enum logic [1:0] {
      PVIC_TRIG_LOW = 2'b00,
      PVIC_TRIG_RISE = 2'b01,
      PVIC_TRIG_FALL = 2'b10,
      PVIC_TRIG_BOTH = 2'b11
   } pvic_trig_t;

   // Opens a gap at 4 so the pin's fixed slot sits mid-level
   function automatic logic [3:0] pvic_sub_rank(input logic [2:0] s);
      logic [3:0] r;
      r = {1'b0, s};
      if (s >= SUB_SPLIT) begin
         r = r + 4'h1;
      end
      return r;
   endfunction

   function automatic logic [31:0] pvic_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction
endpackage

// [hdl/pvic_edge_port.sv]
`timescale 1ns/10ps
`default_nettype none
module pvic_edge_port
   import pvic_pkg::*;
#(
   parameter int NPIN_P = NPIN
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [NPIN_P:1] pin_n,
   input wire logic [2*NPIN_P-1:0] trig_cfg,
   input wire logic [NPIN_P:1] flag_clr,
   output logic [NPIN_P:1] flag
);
   logic [NPIN_P:1] pin_prev_q;

   // Idle pins are high, so no false edge after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_prev_q <= '1;
      end else begin
         pin_prev_q <= pin_n;
      end
   end

   genvar i;
   for (i = 1; i <= NPIN_P; i++) begin : g_pin
      pvic_trig_t mode;
      logic rise;
      logic fall;
      logic hit;
      logic flag_bit_q;
      assign mode = pvic_trig_t'(trig_cfg[2*(i-1) +: 2]);
      assign rise = pin_n[i] & ~pin_prev_q[i];
      assign fall = ~pin_n[i] & pin_prev_q[i];
      always_comb begin
         unique case (mode)
            PVIC_TRIG_LOW: hit = ~pin_n[i];
            PVIC_TRIG_RISE: hit = rise;
            PVIC_TRIG_FALL: hit = fall;
            PVIC_TRIG_BOTH: hit = rise | fall;
         endcase
      end
      // Level mode follows the pin; edge modes latch until cleared
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            flag_bit_q <= 1'b0;
         end else if (mode == PVIC_TRIG_LOW) begin
            flag_bit_q <= hit;
         end else if (hit) begin
            flag_bit_q <= 1'b1;
         end else if (flag_clr[i]) begin
            flag_bit_q <= 1'b0;
         end
      end
      assign flag[i] = flag_bit_q;

      AST_EDGE_FALL_SETS: assert property (
         @(posedge pclk) disable iff (!presetn)
         (mode == PVIC_TRIG_FALL && fall) |=> flag[i])
         else $error("falling edge did not set pin flag");
      AST_EDGE_FLAG_HOLDS: assert property (
         @(posedge pclk) disable iff (!presetn)
         (flag[i] && mode != PVIC_TRIG_LOW && !flag_clr[i]
          && $stable(mode)) |=> flag[i])
         else $error("pin flag dropped without a clear");
   end
endmodule
`default_nettype wire

// [hdl/pvic_top.sv]
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module pvic_top
   import pvic_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NSRC-1:0] src_req_a,
   input wire logic [NSRC-1:0] src_req_b,
   input wire logic [NPIN:1] ext_req_n,
   output logic [LVL_W-1:0] core_req_level,
   input wire logic ack_req,
   input wire logic [LVL_W-1:0] ack_level,
   output logic ack_done,
   output logic [7:0] ack_vector
);
   logic [63:0] mask_q [2];
   logic [CTL_W-1:0] ctl_q [2][NSRC];
   logic [13:0] pin_cfg_q;
   logic [31:0] prdata_q;
   logic [LVL_W-1:0] core_req_level_q;
   logic ack_done_q;
   logic [7:0] ack_vector_q;

   logic [NSRC-1:0] src_req [2];
   logic [NPIN:1] pin_flag;
   logic [NPIN:1] pin_clr;
   logic src_act [2][NSRC];
   logic [RANK_W-1:0] src_rank [2][NSRC];
   logic [RANK_W-1:0] best_rank [2];
   logic [5:0] best_idx [2];
   logic [RANK_W-1:0] ackm_rank [2];
   logic [5:0] ackm_idx [2];
   logic win_b;
   logic ack_b;
   logic any_act;
   logic [LVL_W-1:0] level_d;
   logic [7:0] ack_vector_d;

   logic setup;
   logic access;
   logic wr;
   logic u_hit;
   logic u_sel;
   logic [8:0] u_off;
   logic [5:0] idx;
   logic hit_mhi;
   logic hit_mlo;
   logic hit_stat;
   logic hit_ctl;
   logic hit_pcfg;
   logic hit_pflag;
   logic hit_plvl;
   logic hit_clvl;
   logic addr_err;
   logic [31:0] rd_mux;
   logic [31:0] wdata_m;

   assign src_req[0] = src_req_a;
   assign src_req[1] = src_req_b;

   function automatic logic [7:0] pvic_vec(input logic unit,
                                           input logic [5:0] n);
      return (unit ? VEC_BASE_B : VEC_BASE_A) + {2'b00, n};
   endfunction

   // APB slave: zero wait states, read data captured in the setup cycle
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr = access & pwrite & ~addr_err;
   assign pready = 1'b1;
   assign pslverr = access & addr_err;
   assign prdata = prdata_q;

   assign u_hit = (paddr[11:10] == 2'b00);
   assign u_sel = paddr[9];
   assign u_off = paddr[8:0];
   assign idx = paddr[7:2];
   assign hit_mhi = u_hit && u_off == UOFF_MASK_HI;
   assign hit_mlo = u_hit && u_off == UOFF_MASK_LO;
   assign hit_stat = u_hit && u_off == UOFF_STAT;
   // Index 0 has no source behind it and stays unmapped
   assign hit_ctl = u_hit && u_off >= UOFF_CTL && paddr[1:0] == 2'b00
                    && idx != 6'h00;
   assign hit_pcfg = paddr == OFF_PIN_CFG;
   assign hit_pflag = paddr == OFF_PIN_FLAG;
   assign hit_plvl = paddr == OFF_PIN_LVL;
   assign hit_clvl = paddr == OFF_CORE_LVL;
   assign addr_err = ~(hit_mhi | hit_mlo | hit_stat | hit_ctl | hit_pcfg
                       | hit_pflag | hit_plvl | hit_clvl);

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_mhi) begin
         rd_mux = mask_q[u_sel][63:32];
      end else if (hit_mlo) begin
         rd_mux = mask_q[u_sel][31:0];
      end else if (hit_stat) begin
         rd_mux = {16'h0000, pvic_vec(u_sel, best_idx[u_sel]), 5'h00,
                   best_rank[u_sel][RANK_W-1 -: LVL_W]};
      end else if (hit_ctl) begin
         rd_mux = {26'h000_0000, ctl_q[u_sel][idx]};
      end else if (hit_pcfg) begin
         rd_mux = {18'h0_0000, pin_cfg_q};
      end else if (hit_pflag) begin
         rd_mux = {24'h00_0000, pin_flag, 1'b0};
      end else if (hit_plvl) begin
         rd_mux = {24'h00_0000, ~ext_req_n, 1'b0};
      end else if (hit_clvl) begin
         rd_mux = {29'h0000_0000, core_req_level_q};
      end
   end

   // Byte lanes merge into the register's present contents
   assign wdata_m = pvic_merge(rd_mux, pwdata, pstrb);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata_q <= rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q[0] <= MASK_RST;
         mask_q[1] <= MASK_RST;
      end else if (wr && hit_mhi) begin
         mask_q[u_sel][63:32] <= wdata_m;
      end else if (wr && hit_mlo) begin
         mask_q[u_sel][31:0] <= wdata_m;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int u = 0; u < 2; u++) begin
            for (int n = 0; n < NSRC; n++) begin
               ctl_q[u][n] <= CTL_RST;
            end
         end
      end else if (wr && hit_ctl) begin
         ctl_q[u_sel][idx] <= wdata_m[CTL_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_cfg_q <= PIN_CFG_RST;
      end else if (wr && hit_pcfg) begin
         pin_cfg_q <= wdata_m[13:0];
      end
   end

   // Write one to clear; a new edge in the same cycle wins
   assign pin_clr = (wr && hit_pflag && pstrb[0]) ? pwdata[NPIN:1] : '0;

   pvic_edge_port #(
      .NPIN_P(NPIN)
   ) u_edge_port (
      .pclk(pclk),
      .presetn(presetn),
      .pin_n(ext_req_n),
      .trig_cfg(pin_cfg_q),
      .flag_clr(pin_clr),
      .flag(pin_flag)
   );

   // Per-source rank: level in the top bits, widened sub-priority below
   genvar gu, gn;
   for (gu = 0; gu < 2; gu++) begin : g_unit
      for (gn = 0; gn < NSRC; gn++) begin : g_src
         if (gn == 0) begin : g_none
            assign src_act[gu][gn] = 1'b0;
            assign src_rank[gu][gn] = '0;
         end else if (gu == 0 && gn <= NPIN) begin : g_fixed
            assign src_rank[gu][gn] = {LVL_W'(gn), SUB_FIXED};
            assign src_act[gu][gn] = pin_flag[gn] & ~mask_q[gu][gn]
                                     & ~mask_q[gu][MASKALL_BIT];
         end else begin : g_prog
            logic [CTL_W-1:0] c;
            assign c = ctl_q[gu][gn];
            assign src_rank[gu][gn] = {c[CTL_W-1 -: LVL_W],
                                       pvic_sub_rank(c[2:0])};
            // Level 0 leaves a source unable to request
            assign src_act[gu][gn] = src_req[gu][gn] & ~mask_q[gu][gn]
                                     & ~mask_q[gu][MASKALL_BIT]
                                     & (c[CTL_W-1 -: LVL_W] != '0);
         end
      end
   end

   // Strict compare: equal ranks keep the lower index (software keeps
   // ranks unique, so this is only a defined fallback)
   always_comb begin
      for (int u = 0; u < 2; u++) begin
         best_rank[u] = '0;
         best_idx[u] = 6'h00;
         ackm_rank[u] = '0;
         ackm_idx[u] = 6'h00;
         for (int n = 1; n < NSRC; n++) begin
            if (src_act[u][n] && src_rank[u][n] > best_rank[u]) begin
               best_rank[u] = src_rank[u][n];
               best_idx[u] = 6'(n);
            end
            if (src_act[u][n] && src_rank[u][n] > ackm_rank[u]
                && src_rank[u][n][RANK_W-1 -: LVL_W] == ack_level) begin
               ackm_rank[u] = src_rank[u][n];
               ackm_idx[u] = 6'(n);
            end
         end
      end
   end

   assign win_b = best_rank[1] > best_rank[0];
   assign ack_b = ackm_rank[1] > ackm_rank[0];
   assign any_act = (best_rank[0] != '0) || (best_rank[1] != '0);
   assign level_d = win_b ? best_rank[1][RANK_W-1 -: LVL_W]
                          : best_rank[0][RANK_W-1 -: LVL_W];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_req_level_q <= '0;
      end else begin
         core_req_level_q <= level_d;
      end
   end
   assign core_req_level = core_req_level_q;

   // Nothing pending at the acknowledged level gives the spurious vector
   always_comb begin
      if (ackm_rank[0] == '0 && ackm_rank[1] == '0) begin
         ack_vector_d = VEC_SPURIOUS;
      end else if (ack_b) begin
         ack_vector_d = pvic_vec(1'b1, ackm_idx[1]);
      end else begin
         ack_vector_d = pvic_vec(1'b0, ackm_idx[0]);
      end
   end

   // Answered here, one cycle after the request; never leaves the block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_done_q <= 1'b0;
         ack_vector_q <= 8'h00;
      end else begin
         ack_done_q <= ack_req & ~ack_done_q;
         if (ack_req && !ack_done_q) begin
            ack_vector_q <= ack_vector_d;
         end
      end
   end
   assign ack_done = ack_done_q;
   assign ack_vector = ack_vector_q;

   AST_LEVEL_IDLE: assert property (
      @(posedge pclk) disable iff (!presetn)
      !any_act |=> core_req_level == 3'h0)
      else $error("level shown with nothing pending");

   AST_LEVEL_LIVE: assert property (
      @(posedge pclk) disable iff (!presetn)
      any_act |=> core_req_level != 3'h0)
      else $error("pending source not presented to core");

   AST_MASK_ALL: assert property (
      @(posedge pclk) disable iff (!presetn)
      (mask_q[0][MASKALL_BIT] && mask_q[1][MASKALL_BIT])
      |=> core_req_level == 3'h0)
      else $error("global mask did not block requests");

   AST_ACK_PULSE: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ack_req && !ack_done) |=> ack_done ##1 !ack_done)
      else $error("acknowledge not answered in one cycle");

   AST_VEC_USER: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ack_done && ack_vector != VEC_SPURIOUS)
      |-> ack_vector >= VEC_USER_MIN)
      else $error("source vector in reserved range");

   AST_TIE_PRIMARY: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ack_req && !ack_done && ackm_rank[0] != '0
       && ackm_rank[0] == ackm_rank[1])
      |=> ack_vector >= VEC_BASE_A && ack_vector < VEC_BASE_B)
      else $error("tie not given to primary unit");

   AST_MASK_WRITE: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr && hit_mlo && !u_sel && pstrb == 4'hf)
      |=> mask_q[0][31:0] == $past(pwdata))
      else $error("mask low write not stored");

   AST_MASK_HI_WRITE: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr && hit_mhi && u_sel && pstrb == 4'hf)
      |=> mask_q[1][63:32] == $past(pwdata))
      else $error("mask high write not stored");

   // A refused write must leave every mask bit alone
   AST_ERR_NO_WRITE: assert property (
      @(posedge pclk) disable iff (!presetn)
      (access && pwrite && addr_err)
      |=> $stable(mask_q[0]) && $stable(mask_q[1]))
      else $error("unmapped write changed a mask");

   // Core must never see an answer it did not ask for
   AST_ACK_ONLY_ASKED: assert property (
      @(posedge pclk) disable iff (!presetn)
      !ack_req |=> !ack_done)
      else $error("acknowledge answered without a request");

   // Vector must stand until the core's next acknowledge
   AST_VEC_STANDS: assert property (
      @(posedge pclk) disable iff (!presetn)
      !(ack_req && !ack_done) |=> $stable(ack_vector))
      else $error("vector changed without an acknowledge");

   // Empty level still gets an answer, never a stale vector
   AST_ACK_SPURIOUS: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ack_req && !ack_done && ackm_rank[0] == '0 && ackm_rank[1] == '0)
      |=> ack_vector == VEC_SPURIOUS)
      else $error("empty level did not give the spurious vector");

   AST_SECOND_WINS: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ack_req && !ack_done && ackm_rank[1] > ackm_rank[0])
      |=> ack_vector >= VEC_BASE_B)
      else $error("higher secondary request not served");
endmodule
`default_nettype wire

// [bench/pvic_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
module pvic_core_model
   import pvic_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic auto_en,
   input wire logic [LVL_W-1:0] core_req_level,
   input wire logic ack_done,
   input wire logic [7:0] ack_vector,
   output logic ack_req,
   output logic [LVL_W-1:0] ack_level,
   output logic [7:0] last_vec,
   output int n_ack
);
   logic [2:0] sr_mask = 3'h0;
   logic [2:0] prev_lvl = 3'h0;
   logic [2:0] cur;
   logic [7:0] v;
   // Handler pointer offset and stacked words, two per frame
   logic [9:0] table_off = 10'h000;
   int frame_words = 0;
   initial begin
      ack_req = 1'b0;
      ack_level = 3'h0;
      last_vec = 8'h00;
      n_ack = 0;
   end
   // Entered just after an edge; request held until the answer
   task automatic do_ack(input logic [2:0] l, output logic [7:0] vec);
      ack_req <= 1'b1;
      ack_level <= l;
      @(posedge pclk);
      while (ack_done !== 1'b1) @(posedge pclk);
      vec = ack_vector;
      ack_req <= 1'b0;
      @(posedge pclk);
   endtask
   always begin
      @(posedge pclk);
      cur = core_req_level;
      if (!auto_en || !presetn) begin
         sr_mask = 3'h0;
      end
      // Level 7 ignores the mask but is taken on its rising edge only
      else if (cur > sr_mask || (cur == 3'h7 && prev_lvl != 3'h7)) begin
         do_ack(cur, v);
         last_vec = v;
         frame_words += 2;
         table_off = {v, 2'b00};
         sr_mask = cur;
         n_ack++;
      end
      prev_lvl = cur;
   end
endmodule
`default_nettype wire

// [bench/pvic_top_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module pvic_top_bench
   import pvic_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [NSRC-1:0] src_req_a = '0;
   logic [NSRC-1:0] src_req_b = '0;
   logic [NPIN:1] ext_req_n = '1;
   logic [LVL_W-1:0] core_req_level;
   logic ack_req;
   logic [LVL_W-1:0] ack_level;
   logic ack_done;
   logic [7:0] ack_vector;
   logic auto_en = 1'b0;
   logic [7:0] last_vec;
   int n_ack;
   int bad_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int lv[2][64];
   int sb[2][64];
   bit rq[2][64];
   bit mk[2][64];
   bit gm[2];
   bit pa[8];
   logic [31:0] rd;
   logic e;
   always #5 pclk = ~pclk;
   pvic_top pvic_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_req_a(src_req_a), .src_req_b(src_req_b), .ext_req_n(ext_req_n),
      .core_req_level(core_req_level), .ack_req(ack_req),
      .ack_level(ack_level), .ack_done(ack_done), .ack_vector(ack_vector));
   pvic_core_model pvic_core_model_i (.pclk(pclk), .presetn(presetn),
      .auto_en(auto_en), .core_req_level(core_req_level),
      .ack_done(ack_done), .ack_vector(ack_vector), .ack_req(ack_req),
      .ack_level(ack_level), .last_vec(last_vec), .n_ack(n_ack));
   task automatic complete_run;
      if (bad_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         bad_count++;
         complete_run();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t %h %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [11:0] ub(input int u);
      return (u != 0) ? OFF_UNIT_B : 12'h000;
   endfunction
   task automatic set_ctl(input int u, input int n, input int l, input int s);
      apb(1'b1, ub(u) + UOFF_CTL + 12'(4 * n), 32'(l * 8 + s));
      lv[u][n] = l;
      sb[u][n] = s;
   endtask
   task automatic set_mask(input int u, input logic [63:0] m);
      apb(1'b1, ub(u) + UOFF_MASK_HI, m[63:32]);
      apb(1'b1, ub(u) + UOFF_MASK_LO, m[31:0]);
      for (int n = 0; n < 64; n++) mk[u][n] = m[n];
      gm[u] = m[0];
   endtask
   task automatic push;
      logic [63:0] a;
      logic [63:0] b;
      for (int n = 0; n < 64; n++) begin
         a[n] = rq[0][n];
         b[n] = rq[1][n];
      end
      src_req_a <= a;
      src_req_b <= b;
   endtask
   function automatic int rank(input int u, input int n);
      int l;
      int s;
      bit p;
      if (u == 0 && n <= NPIN) begin
         p = pa[n];
         l = n;
         s = 4;
      end else begin
         p = rq[u][n];
         l = lv[u][n];
         s = (sb[u][n] < 4) ? sb[u][n] : sb[u][n] + 1;
      end
      if (!p || l == 0 || mk[u][n] || gm[u]) return -1;
      return l * 10 + s;
   endfunction
   // Strict compare: primary unit and lower index keep ties
   function automatic int pick(input int lvl, output int v);
      int r;
      int br;
      br = -1;
      v = VEC_SPURIOUS;
      for (int u = 0; u < 2; u++) begin
         for (int n = 1; n < 64; n++) begin
            r = rank(u, n);
            if (r > br && (lvl == 0 || r / 10 == lvl)) begin
               br = r;
               v = ((u != 0) ? VEC_BASE_B : VEC_BASE_A) + n;
            end
         end
      end
      return br;
   endfunction
   task automatic check_all;
      int v;
      int br;
      logic [7:0] got;
      repeat (5) @(posedge pclk);
      br = pick(0, v);
      check(32'(core_req_level), (br < 0) ? 0 : br / 10);
      apb(1'b0, OFF_CORE_LVL, 32'h0);
      check(rd, (br < 0) ? 0 : br / 10);
      for (int l = 1; l < 8; l++) begin
         br = pick(l, v);
         pvic_core_model_i.do_ack(3'(l), got);
         check(32'(got), v);
      end
      br = pick(0, v);
      check(32'(core_req_level), (br < 0) ? 0 : br / 10);
   endtask
   initial begin
      void'($urandom(93318));
      for (int n = 0; n < 64; n++) begin
         mk[0][n] = 1'b1;
         mk[1][n] = 1'b1;
      end
      gm = '{1'b1, 1'b1};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ub(1) + UOFF_MASK_LO, 32'h0);
      check(rd, 32'hffffffff);
      apb(1'b0, 12'h800, 32'h0);
      check(32'(e), 32'h1);
      apb(1'b1, 12'h800, 32'h0);
      check(32'(e), 32'h1);
      check(32'(core_req_level), 32'h0);
      set_ctl(0, 40, 4, 5);
      set_ctl(1, 40, 4, 5);
      rq[0][40] = 1'b1;
      rq[1][40] = 1'b1;
      push();
      set_mask(0, ~(64'h1 << 40) & ~64'h1);
      set_mask(1, ~(64'h1 << 40) & ~64'h1);
      check_all();
      set_ctl(1, 40, 4, 6);
      apb(1'b0, ub(1) + UOFF_CTL + 12'd160, 32'h0);
      check(rd, 32'h26);
      check_all();
      set_mask(0, ~(64'h1 << 40));
      check_all();
      set_mask(0, ~(64'h100028 | 64'h1));
      set_ctl(0, 20, 3, 3);
      rq[0][20] = 1'b1;
      push();
      ext_req_n[3] <= 1'b0;
      pa[3] = 1'b1;
      check_all();
      set_ctl(0, 20, 3, 4);
      check_all();
      ext_req_n[3] <= 1'b1;
      pa[3] = 1'b0;
      // Edge modes: sticky flag outlives the pulse, write one clears
      for (int md = 1; md < 4; md++) begin
         apb(1'b1, OFF_PIN_CFG, 32'(md) << 8);
         ext_req_n[5] <= 1'b0;
         // Flag seen before the release tells rising mode apart from falling and both
         apb(1'b0, OFF_PIN_FLAG, 32'h0);
         check(32'(rd[5]), 32'(md != 1));
         ext_req_n[5] <= 1'b1;
         pa[5] = 1'b1;
         check_all();
         apb(1'b0, OFF_PIN_FLAG, 32'h0);
         check(32'(rd[5]), 32'h1);
         apb(1'b1, OFF_PIN_FLAG, 32'h20);
         pa[5] = 1'b0;
         check_all();
      end
      set_mask(0, '1);
      set_ctl(1, 1, 5, 0);
      rq[1][1] = 1'b1;
      push();
      set_mask(1, ~64'h7);
      auto_en <= 1'b1;
      repeat (20) @(posedge pclk);
      check(32'(last_vec), 32'h81);
      check(32'(core_req_level), 32'h5);
      set_ctl(1, 2, 7, 0);
      rq[1][2] = 1'b1;
      push();
      repeat (30) @(posedge pclk);
      check(32'(last_vec), 32'h82);
      check(n_ack, 32'h2);
      check(32'(pvic_core_model_i.table_off), 32'h208);
      check(pvic_core_model_i.frame_words, 32'h4);
      auto_en <= 1'b0;
      repeat (4) @(posedge pclk);
      for (int it = 0; it < 25; it++) begin
         repeat (6) set_ctl($urandom % 2, 1 + $urandom % 63, $urandom % 8,
                            $urandom % 8);
         for (int n = 0; n < 64; n++) begin
            rq[0][n] = (n > NPIN) ? $urandom % 2 : 0;
            rq[1][n] = (n > 0) ? $urandom % 2 : 0;
         end
         push();
         set_mask(0, {$urandom, $urandom} | 64'($urandom % 4 == 0));
         set_mask(1, {$urandom, $urandom} | 64'($urandom % 4 == 0));
         check_all();
      end
      complete_run();
   end
endmodule
`default_nettype wire
